// file: hdl/bts_defs.svh
`ifndef BTS_DEFS_SVH
`define BTS_DEFS_SVH

// ==========================================
// widths
`define BTS_DATA_W 8
`define BTS_ADDR_W 16

// ==========================================
// instruction bytes and fields
`define BTS_PFX_BITOP 8'hCB
`define BTS_PFX_IDX1 8'hDD
`define BTS_PFX_IDX2 8'hFD
`define BTS_GRP_HI 7
`define BTS_GRP_LO 6
`define BTS_POS_HI 5
`define BTS_POS_LO 3
`define BTS_SLOT_HI 2
`define BTS_SLOT_LO 0
`define BTS_GRP_TEST 2'b01
`define BTS_GRP_SET 2'b11
`define BTS_SLOT_MEM 3'b110

// ==========================================
// condition byte layout and reset value
`define BTS_FLG_SIGN 7
`define BTS_FLG_ZERO 6
`define BTS_FLG_NIB 4
`define BTS_FLG_PV 2
`define BTS_FLG_SUB 1
`define BTS_FLG_CY 0
`define BTS_FLAGS_RST 8'h00
`define BTS_REG_RST 8'h00
`define BTS_ADDR_RST 16'h0000

// ==========================================
// machine cycle lengths in clock states, and cycle indices
`define BTS_T_SHORT 3'd3
`define BTS_T_NORM 3'd4
`define BTS_T_LONG 3'd5
`define BTS_M_REG_LAST 3'd1
`define BTS_M_PTR_READ 3'd2
`define BTS_M_IDX_SHORT 3'd2
`define BTS_M_IDX_LONG 3'd3
`define BTS_M_IDX_READ 3'd4

`endif

// file: hdl/bts_pkg.sv
package bts_pkg;

   typedef enum logic [1:0] {
      BTS_FORM_REG,
      BTS_FORM_PTR,
      BTS_FORM_IDX1,
      BTS_FORM_IDX2
   } bts_form_e;

   typedef enum logic {
      BTS_IDLE,
      BTS_RUN
   } bts_state_e;

endpackage

// file: hdl/bts_dec_if.sv
`timescale 1ns/1ps
`default_nettype none

interface bts_dec_if;
   logic [7:0]         prefix;
   logic [7:0]         opcode;
   logic               legal;
   logic               is_set;
   bts_pkg::bts_form_e form;
   logic [2:0]         bit_pos;
   logic [2:0]         slot;

   modport dec (
      input  prefix,
      input  opcode,
      output legal,
      output is_set,
      output form,
      output bit_pos,
      output slot
   );

   modport use_side (
      output prefix,
      output opcode,
      input  legal,
      input  is_set,
      input  form,
      input  bit_pos,
      input  slot
   );
endinterface

`default_nettype wire

// file: hdl/bts_decode.sv
`timescale 1ns/1ps
`default_nettype none
`include "bts_defs.svh"

module bts_decode (
   bts_dec_if.dec dif
);
   logic [1:0] grp;

   always_comb begin
      grp         = dif.opcode[`BTS_GRP_HI:`BTS_GRP_LO];
      dif.bit_pos = dif.opcode[`BTS_POS_HI:`BTS_POS_LO];
      dif.slot    = dif.opcode[`BTS_SLOT_HI:`BTS_SLOT_LO];
      dif.is_set  = (grp == `BTS_GRP_SET);
      dif.legal   = (grp == `BTS_GRP_TEST) || (grp == `BTS_GRP_SET);
      dif.form    = bts_pkg::BTS_FORM_REG;
      unique case (dif.prefix)
         `BTS_PFX_BITOP: begin
            if (dif.slot == `BTS_SLOT_MEM) begin
               dif.form = bts_pkg::BTS_FORM_PTR;
            end
         end
         `BTS_PFX_IDX1: begin
            dif.form  = bts_pkg::BTS_FORM_IDX1;
            dif.legal = dif.legal && (dif.slot == `BTS_SLOT_MEM);
         end
         `BTS_PFX_IDX2: begin
            dif.form  = bts_pkg::BTS_FORM_IDX2;
            dif.legal = dif.legal && (dif.slot == `BTS_SLOT_MEM);
         end
         default: begin
            dif.legal = 1'b0;
         end
      endcase
   end
endmodule // bts_decode

`default_nettype wire

// file: hdl/bts_unit.sv
`timescale 1ns/1ps
`default_nettype none
`include "bts_defs.svh"


module bts_unit #(
   parameter int DATA_W = `BTS_DATA_W,
   parameter int ADDR_W = `BTS_ADDR_W
) (
   input  wire logic              sys_clk,
   input  wire logic              sys_rst,
   input  wire logic              cmd_valid,
   input  wire logic [7:0]        cmd_prefix,
   input  wire logic [7:0]        cmd_opcode,
   input  wire logic [7:0]        offset_byte,
   output logic                   cmd_ready,
   output logic                   cmd_done,
   output logic                   cmd_error,
   input  wire logic [ADDR_W-1:0] pointer_pair,
   input  wire logic [ADDR_W-1:0] first_index_base,
   input  wire logic [ADDR_W-1:0] second_index_base,
   input  wire logic              gp_load,
   input  wire logic [2:0]        gp_load_slot,
   input  wire logic [DATA_W-1:0] gp_load_data,
   input  wire logic [2:0]        gp_read_slot,
   output logic [DATA_W-1:0]      gp_read_data,
   input  wire logic              flag_load,
   input  wire logic [DATA_W-1:0] flag_load_data,
   output logic [DATA_W-1:0]      condition_byte,
   output logic [ADDR_W-1:0]      mem_addr,
   output logic                   mem_rd,
   output logic                   mem_wr,
   output logic [DATA_W-1:0]      mem_wdata,
   input  wire logic [DATA_W-1:0] mem_rdata
);

   // ==========================================
   // parameter check
   if (DATA_W != 8 || ADDR_W <= 8) begin : g_bad_param
      $error("bts_unit needs DATA_W of 8 and ADDR_W above 8");
   end

   // ==========================================
   // helpers
   function automatic logic [2:0] mcyc_len(bts_pkg::bts_form_e form, logic [2:0] m);
      logic [2:0] len;
      len = `BTS_T_NORM;
      if (form == bts_pkg::BTS_FORM_IDX1 || form == bts_pkg::BTS_FORM_IDX2) begin
         if (m == `BTS_M_IDX_SHORT || m == `BTS_M_IDX_READ + 3'd1) begin
            len = `BTS_T_SHORT;
         end else if (m == `BTS_M_IDX_LONG) begin
            len = `BTS_T_LONG;
         end
      end else if (form == bts_pkg::BTS_FORM_PTR && m == `BTS_M_PTR_READ + 3'd1) begin
         len = `BTS_T_SHORT;
      end
      return len;
   endfunction

   function automatic logic [2:0] read_mcyc(bts_pkg::bts_form_e form);
      return (form == bts_pkg::BTS_FORM_PTR) ? `BTS_M_PTR_READ : `BTS_M_IDX_READ;
   endfunction

   function automatic logic [2:0] last_mcyc(bts_pkg::bts_form_e form, logic set);
      logic [2:0] last;
      if (form == bts_pkg::BTS_FORM_REG) begin
         last = `BTS_M_REG_LAST;
      end else begin
         last = read_mcyc(form) + {2'b00, set};
      end
      return last;
   endfunction

   function automatic logic [DATA_W-1:0] bit_mask(logic [2:0] pos);
      logic [DATA_W-1:0] mask;
      mask      = '0;
      mask[pos] = 1'b1;
      return mask;
   endfunction

   function automatic logic [ADDR_W-1:0] index_addr(logic [ADDR_W-1:0] base, logic [7:0] off);
      return base + {{(ADDR_W - 8){off[7]}}, off};
   endfunction

   // ==========================================
   // decoder
   bts_dec_if dif ();

   assign dif.prefix = cmd_prefix;
   assign dif.opcode = cmd_opcode;

   bts_decode u_decode (
      .dif (dif.dec)
   );

   // ==========================================
   // state
   bts_pkg::bts_state_e state;
   bts_pkg::bts_state_e next_state;
   bts_pkg::bts_form_e  form;
   bts_pkg::bts_form_e  next_form;
   logic                is_set;
   logic                next_is_set;
   logic [2:0]          bit_pos;
   logic [2:0]          next_bit_pos;
   logic [2:0]          slot;
   logic [2:0]          next_slot;
   logic [2:0]          mcnt;
   logic [2:0]          next_mcnt;
   logic [2:0]          tcnt;
   logic [2:0]          next_tcnt;
   logic [DATA_W-1:0]   gp [8];
   logic [DATA_W-1:0]   next_gp [8];
   logic [DATA_W-1:0]   next_condition_byte;
   logic [DATA_W-1:0]   next_gp_read_data;
   logic [ADDR_W-1:0]   next_mem_addr;
   logic                next_mem_rd;
   logic                next_mem_wr;
   logic [DATA_W-1:0]   next_mem_wdata;
   logic                next_cmd_ready;
   logic                next_cmd_done;
   logic                next_cmd_error;
   logic [DATA_W-1:0]   operand;
   logic                tested;

   always_comb begin
      next_state          = state;
      next_form           = form;
      next_is_set         = is_set;
      next_bit_pos        = bit_pos;
      next_slot           = slot;
      next_mcnt           = mcnt;
      next_tcnt           = tcnt;
      next_gp             = gp;
      next_condition_byte = condition_byte;
      next_mem_addr       = mem_addr;
      next_mem_wdata      = mem_wdata;
      next_cmd_done       = 1'b0;
      next_cmd_error      = 1'b0;
      operand             = '0;
      tested              = 1'b0;

      if (gp_load && gp_load_slot != `BTS_SLOT_MEM) begin
         next_gp[gp_load_slot] = gp_load_data;
      end
      if (flag_load) begin
         next_condition_byte = flag_load_data;
      end

      unique case (state)
         bts_pkg::BTS_IDLE: begin
            if (cmd_valid) begin
               if (dif.legal) begin
                  next_state   = bts_pkg::BTS_RUN;
                  next_form    = dif.form;
                  next_is_set  = dif.is_set;
                  next_bit_pos = dif.bit_pos;
                  next_slot    = dif.slot;
                  next_mcnt    = '0;
                  next_tcnt    = '0;
                  unique case (dif.form)
                     bts_pkg::BTS_FORM_PTR: next_mem_addr = pointer_pair;
                     bts_pkg::BTS_FORM_IDX1: next_mem_addr = index_addr(first_index_base, offset_byte);
                     bts_pkg::BTS_FORM_IDX2: next_mem_addr = index_addr(second_index_base, offset_byte);
                     bts_pkg::BTS_FORM_REG: next_mem_addr = mem_addr;
                  endcase
               end else begin
                  next_cmd_error = 1'b1;
               end
            end
         end
         bts_pkg::BTS_RUN: begin
            if (tcnt == mcyc_len(form, mcnt) - 3'd1) begin
               next_tcnt = '0;
               next_mcnt = mcnt + 3'd1;
               if (form == bts_pkg::BTS_FORM_REG) begin
                  operand = gp[slot];
               end else begin
                  operand = mem_rdata;
               end
               tested = operand[bit_pos];
               if (mcnt == last_mcyc(form, is_set)) begin
                  next_state    = bts_pkg::BTS_IDLE;
                  next_cmd_done = 1'b1;
                  if (!is_set) begin
                     next_condition_byte[`BTS_FLG_ZERO] = ~tested;
                     next_condition_byte[`BTS_FLG_NIB] = 1'b1;
                     next_condition_byte[`BTS_FLG_SUB] = 1'b0;
                  end else if (form == bts_pkg::BTS_FORM_REG) begin
                     next_gp[slot] = gp[slot] | bit_mask(bit_pos);
                  end
               end else if (form != bts_pkg::BTS_FORM_REG && mcnt == read_mcyc(form)) begin
                  next_mem_wdata = mem_rdata | bit_mask(bit_pos);
               end
            end else begin
               next_tcnt = tcnt + 3'd1;
            end
         end
      endcase

      next_mem_rd = next_state == bts_pkg::BTS_RUN && next_form != bts_pkg::BTS_FORM_REG
                    && next_mcnt == read_mcyc(next_form);
      next_mem_wr = next_state == bts_pkg::BTS_RUN && next_form != bts_pkg::BTS_FORM_REG
                    && next_is_set && next_mcnt == read_mcyc(next_form) + 3'd1;
      next_cmd_ready    = next_state == bts_pkg::BTS_IDLE;
      next_gp_read_data = next_gp[gp_read_slot];
   end

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         state          <= bts_pkg::BTS_IDLE;
         form           <= bts_pkg::BTS_FORM_REG;
         is_set         <= 1'b0;
         bit_pos        <= '0;
         slot           <= '0;
         mcnt           <= '0;
         tcnt           <= '0;
         for (int i = 0; i < 8; i++) begin
            gp[i] <= `BTS_REG_RST;
         end
         condition_byte <= `BTS_FLAGS_RST;
         gp_read_data   <= `BTS_REG_RST;
         mem_addr       <= `BTS_ADDR_RST;
         mem_rd         <= 1'b0;
         mem_wr         <= 1'b0;
         mem_wdata      <= `BTS_REG_RST;
         cmd_ready      <= 1'b1;
         cmd_done       <= 1'b0;
         cmd_error      <= 1'b0;
      end else begin
         state          <= next_state;
         form           <= next_form;
         is_set         <= next_is_set;
         bit_pos        <= next_bit_pos;
         slot           <= next_slot;
         mcnt           <= next_mcnt;
         tcnt           <= next_tcnt;
         gp             <= next_gp;
         condition_byte <= next_condition_byte;
         gp_read_data   <= next_gp_read_data;
         mem_addr       <= next_mem_addr;
         mem_rd         <= next_mem_rd;
         mem_wr         <= next_mem_wr;
         mem_wdata      <= next_mem_wdata;
         cmd_ready      <= next_cmd_ready;
         cmd_done       <= next_cmd_done;
         cmd_error      <= next_cmd_error;
      end
   end

endmodule // bts_unit

`default_nettype wire

// file: dv/bts_mem_model.sv
`timescale 1ns/1ps
`default_nettype none

module bts_mem_model (
   input  wire logic        sys_clk,
   input  wire logic [15:0] mem_addr,
   input  wire logic        mem_rd,
   input  wire logic        mem_wr,
   input  wire logic [7:0]  mem_wdata,
   output logic [7:0]       mem_rdata
);
   // ====
   // byte store, low address byte only
   logic [7:0] m [0:255];
   logic [7:0] last = 8'h00;

   // an idle bus shows the inverse of the last byte, never a stale copy
   assign mem_rdata = mem_rd ? m[mem_addr[7:0]] : ~last;

   always @(posedge sys_clk) begin
      if (mem_rd) begin
         last <= m[mem_addr[7:0]];
      end
      if (mem_wr) begin
         m[mem_addr[7:0]] <= mem_wdata;
      end
   end
endmodule // bts_mem_model

`default_nettype wire

// file: dv/bts_unit_assertions.sv
`timescale 1ns/1ps
`default_nettype none
`include "bts_defs.svh"

module bts_unit_assertions #(
   parameter int ADDR_W = 16
) (
   input wire logic              sys_clk,
   input wire logic              sys_rst,
   input wire logic              cmd_valid,
   input wire logic              cmd_ready,
   input wire logic [7:0]        cmd_prefix,
   input wire logic [7:0]        cmd_opcode,
   input wire logic [7:0]        offset_byte,
   input wire logic              cmd_done,
   input wire logic              cmd_error,
   input wire logic [ADDR_W-1:0] pointer_pair,
   input wire logic [ADDR_W-1:0] first_index_base,
   input wire logic [ADDR_W-1:0] second_index_base,
   input wire logic [7:0]        condition_byte,
   input wire logic [ADDR_W-1:0] mem_addr,
   input wire logic              mem_rd,
   input wire logic              mem_wr,
   input wire logic [7:0]        mem_wdata
);
   // ====
   // command capture
   logic [4:0]        cnt;
   logic [4:0]        exp_n;
   logic [ADDR_W-1:0] a_exp;
   logic [7:0]        flg0;
   logic [7:0]        mask;
   logic              is_set;
   wire logic acc = cmd_valid && cmd_ready;
   wire logic idx = cmd_prefix == `BTS_PFX_IDX1 || cmd_prefix == `BTS_PFX_IDX2;
   wire logic mem = cmd_opcode[2:0] == `BTS_SLOT_MEM;
   wire logic ok = cmd_opcode[6] && (cmd_prefix == `BTS_PFX_BITOP || idx && mem);
   wire logic [ADDR_W-1:0] base = cmd_prefix == `BTS_PFX_IDX1 ? first_index_base : second_index_base;

   always_ff @(posedge sys_clk) begin
      if (acc) begin
         cnt <= 5'h00;
         is_set <= cmd_opcode[7];
         flg0 <= condition_byte;
         mask <= 8'h01 << cmd_opcode[5:3];
         a_exp <= idx ? base + {{(ADDR_W-8){offset_byte[7]}}, offset_byte} : pointer_pair;
         exp_n <= !idx && !mem ? 5'd8 : idx ? (cmd_opcode[7] ? 5'd23 : 5'd20) : (cmd_opcode[7] ? 5'd15 : 5'd12);
      end else begin
         cnt <= cnt + 5'd1;
      end
   end

   // ====
   // properties
   default clocking @(posedge sys_clk); endclocking
   default disable iff (sys_rst);

   AST_REG_LEN: assert property (cmd_done && exp_n == 5'd8 |-> cnt == 5'd8)
      else $error("register form length wrong");
   AST_PTR_TEST_LEN: assert property (cmd_done && exp_n == 5'd12 |-> cnt == 5'd12)
      else $error("pointer test length wrong");
   AST_PTR_SET_LEN: assert property (cmd_done && exp_n == 5'd15 |-> cnt == 5'd15)
      else $error("pointer set length wrong");
   AST_IDX_LEN: assert property (cmd_done && exp_n == 5'd20 |-> cnt == 5'd20)
      else $error("indexed test length wrong");
   AST_ILLEGAL: assert property (acc && !ok |=> cmd_error)
      else $error("illegal command not refused");
   AST_BUSY: assert property (acc && ok |=> !cmd_ready[*8])
      else $error("ready during execution");
   AST_RD_ADDR: assert property (mem_rd |-> mem_addr == a_exp)
      else $error("read address wrong");
   AST_WR: assert property (mem_wr |-> is_set && mem_addr == a_exp && (mem_wdata & mask) == mask)
      else $error("write back wrong");
   AST_SET_FLAGS: assert property (cmd_done && is_set |-> condition_byte == flg0)
      else $error("set changed flags");
   AST_TEST_FLAGS: assert property (cmd_done && !is_set |-> condition_byte[`BTS_FLG_NIB]
      && !condition_byte[`BTS_FLG_SUB] && condition_byte[`BTS_FLG_CY] == flg0[`BTS_FLG_CY])
      else $error("test flags wrong");

   cover property (acc && !ok);
   cover property (mem_wr);
   cover property (cmd_done && exp_n == 5'd20);
endmodule // bts_unit_assertions

bind bts_unit bts_unit_assertions #(.ADDR_W(ADDR_W)) chk (
   .sys_clk           (sys_clk),
   .sys_rst           (sys_rst),
   .cmd_valid         (cmd_valid),
   .cmd_ready         (cmd_ready),
   .cmd_prefix        (cmd_prefix),
   .cmd_opcode        (cmd_opcode),
   .offset_byte       (offset_byte),
   .cmd_done          (cmd_done),
   .cmd_error         (cmd_error),
   .pointer_pair      (pointer_pair),
   .first_index_base  (first_index_base),
   .second_index_base (second_index_base),
   .condition_byte    (condition_byte),
   .mem_addr          (mem_addr),
   .mem_rd            (mem_rd),
   .mem_wr            (mem_wr),
   .mem_wdata         (mem_wdata)
);

`default_nettype wire

// file: dv/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "bts_defs.svh"
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin error_cnt++; \
   $display("[ERR] %0t got %0h exp %0h", $time, a, e); end end

module tb_top;
   logic        sys_clk = 1'b0;
   logic        sys_rst = 1'b1;
   logic        cmd_valid, cmd_ready, cmd_done, cmd_error, gp_load, flag_load, mem_rd, mem_wr;
   logic [7:0]  cmd_prefix, cmd_opcode, offset_byte, gp_load_data, gp_read_data;
   logic [7:0]  flag_load_data, condition_byte, mem_wdata, mem_rdata;
   logic [2:0]  gp_load_slot, gp_read_slot;
   logic [15:0] pointer_pair, first_index_base, second_index_base, mem_addr;
   int          error_cnt = 0;
   int          checks_done = 0;

   always #20 sys_clk = ~sys_clk;

   bts_unit uut (
      .sys_clk           (sys_clk),
      .sys_rst           (sys_rst),
      .cmd_valid         (cmd_valid),
      .cmd_prefix        (cmd_prefix),
      .cmd_opcode        (cmd_opcode),
      .offset_byte       (offset_byte),
      .cmd_ready         (cmd_ready),
      .cmd_done          (cmd_done),
      .cmd_error         (cmd_error),
      .pointer_pair      (pointer_pair),
      .first_index_base  (first_index_base),
      .second_index_base (second_index_base),
      .gp_load           (gp_load),
      .gp_load_slot      (gp_load_slot),
      .gp_load_data      (gp_load_data),
      .gp_read_slot      (gp_read_slot),
      .gp_read_data      (gp_read_data),
      .flag_load         (flag_load),
      .flag_load_data    (flag_load_data),
      .condition_byte    (condition_byte),
      .mem_addr          (mem_addr),
      .mem_rd            (mem_rd),
      .mem_wr            (mem_wr),
      .mem_wdata         (mem_wdata),
      .mem_rdata         (mem_rdata)
   );

   bts_mem_model mem (
      .sys_clk   (sys_clk),
      .mem_addr  (mem_addr),
      .mem_rd    (mem_rd),
      .mem_wr    (mem_wr),
      .mem_wdata (mem_wdata),
      .mem_rdata (mem_rdata)
   );

   // ====
   // drivers
   task automatic tick();
      @(posedge sys_clk);
      #1;
   endtask

   task automatic ld(input logic [2:0] s, input logic [7:0] d);
      tick();
      gp_load = 1'b1;
      gp_load_slot = s;
      gp_load_data = d;
      tick();
      gp_load = 1'b0;
   endtask

   task automatic rd(input logic [2:0] s, output logic [7:0] v);
      gp_read_slot = s;
      tick();
      v = gp_read_data;
   endtask

   task automatic run(input logic [7:0] p, input logic [7:0] o, input logic [7:0] d, input int n);
      int k;
      cmd_prefix = p;
      cmd_opcode = o;
      offset_byte = d;
      cmd_valid = 1'b1;
      tick();
      cmd_valid = 1'b0;
      k = 0;
      while (cmd_done !== 1'b1 && k < 30) begin
         tick();
         k++;
      end
      `CHK(k, n)
   endtask

   // ====
   // scenarios
   task automatic t_reg();
      logic [7:0] p, f;
      tick();
      flag_load = 1'b1;
      flag_load_data = 8'h01;
      tick();
      flag_load = 1'b0;
      ld(3'b110, 8'hA5);
      rd(3'b110, f);
      `CHK(f, 8'h00)
      for (int s = 0; s < 8; s++) begin
         if (s == 6) continue;
         p = 8'h1D * (s + 1);
         ld(s[2:0], p);
         for (int b = 0; b < 8; b++) begin
            run(8'hCB, {2'b01, b[2:0], s[2:0]}, 8'h00, 8);
            `CHK({condition_byte[6], condition_byte[4], condition_byte[1:0]}, {~p[b], 3'b101})
         end
         rd(s[2:0], f);
         `CHK(f, p)
         f = condition_byte;
         run(8'hCB, {2'b11, ~s[2:0], s[2:0]}, 8'h00, 8);
         `CHK(condition_byte, f)
         rd(s[2:0], f);
         `CHK(f, p | 8'h80 >> s)
      end
   endtask

   task automatic t_mem();
      pointer_pair = 16'h4444;
      mem.m[8'h44] = 8'h6C;
      for (int b = 0; b < 8; b++) begin
         run(8'hCB, {2'b01, b[2:0], 3'b110}, 8'h00, 12);
         `CHK(condition_byte[6], !(8'h6C >> b & 1))
      end
      `CHK(mem.m[8'h44], 8'h6C)
      run(8'hCB, 8'hFE, 8'h00, 15);
      `CHK(mem.m[8'h44], 8'hEC)
   endtask

   task automatic t_idx();
      first_index_base = 16'h2010;
      second_index_base = 16'h1FF0;
      mem.m[8'h04] = 8'h40;
      run(8'hDD, 8'h76, 8'hF4, 20);
      `CHK(condition_byte[6], 1'b0)
      run(8'hFD, 8'h6E, 8'h14, 20);
      `CHK(condition_byte[6], 1'b1)
      run(8'hDD, 8'hC6, 8'hF4, 23);
      `CHK(mem.m[8'h04], 8'h41)
      run(8'hFD, 8'hFE, 8'h14, 23);
      `CHK(mem.m[8'h04], 8'hC1)
   endtask

   task automatic t_err();
      logic [15:0] bad [4] = '{16'hDD40, 16'hCB86, 16'hED46, 16'hCB06};
      foreach (bad[i]) begin
         cmd_prefix = bad[i][15:8];
         cmd_opcode = bad[i][7:0];
         cmd_valid = 1'b1;
         tick();
         cmd_valid = 1'b0;
         `CHK(cmd_error, 1'b1)
         tick();
      end
   endtask

   task automatic end_of_test();
      $display("TB: errors %0d checks %0d", error_cnt, checks_done);
      if (error_cnt == 0 && checks_done > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   initial begin
      {cmd_valid, gp_load, flag_load} = 3'b000;
      {cmd_prefix, cmd_opcode, offset_byte, gp_load_data, flag_load_data} = 40'h0;
      {gp_load_slot, gp_read_slot} = 6'h00;
      {pointer_pair, first_index_base, second_index_base} = 48'h0;
      repeat (5) @(posedge sys_clk);
      #1;
      sys_rst = 1'b0;
      `CHK({cmd_ready, condition_byte}, 9'h100)
      t_reg();
      t_mem();
      t_idx();
      t_err();
      end_of_test();
   end

   initial begin
      #400000;
      error_cnt++;
      end_of_test();
   end
endmodule // tb_top

`default_nettype wire
